// >>> design/rowc_event_mem.sv
`timescale 1ns/1ps
// Small pending-event store: one flag per event source, registered read
module rowc_event_mem #(
    parameter int N = 6
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [N-1:0] set_i,
    input wire logic [N-1:0] clr_i,
    output logic [N-1:0] pend_o
);
    logic [N-1:0] flags;

    initial begin
        if (N < 1) begin
            $error("rowc_event_mem: N must be at least one");
        end
    end

    // Set wins over clear so an event never gets lost
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr_i) | set_i;
        end
    end

    // Registered read port
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pend_o <= '0;
        end else begin
            pend_o <= (flags & ~clr_i) | set_i;
        end
    end
endmodule // rowc_event_mem

// >>> design/rowc_pkg.sv
// Constants and types of the reset and oscillator wake control block
package rowc_pkg;
    // Clock period in nanoseconds (100 MHz)
    localparam int CLK_PERIOD_NS = 10;
    // Longest reset event after power-up, in milliseconds
    localparam int RESET_HOLD_MS = 150;
    // Reset hold in cycles, longest time rounds down
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    // Command word width and the software reset code
    localparam int CMD_W = 16;
    localparam logic [15:0] CMD_SW_RESET = 16'hFF00;
    // Low battery detector command: top byte code and mode bit position
    localparam logic [7:0] CMD_LOWBAT_CODE = 8'hC2;
    localparam int LOWBAT_MODE_BIT = 6;
    // Default push-button debounce length, in cycles
    localparam int DEBOUNCE_CYC = 16;
    // Number of push-button inputs
    localparam int NUM_BUTTONS = 4;
    // Sequencer states
    typedef enum logic [1:0] {
        ROWC_RESET = 2'b00,
        ROWC_IDLE = 2'b01,
        ROWC_BUSY = 2'b10,
        ROWC_HOLD = 2'b11
    } rowc_state_t;
endpackage

// >>> design/rowc_reset_osc_ctrl.sv
`timescale 1ns/1ps
// Reset sequencing and oscillator wake control of a low-power transmitter
// Notes on behaviour
// - Power-on, a supply glitch or the software reset command resets it.
// - During a reset event, up to 150 ms, serial commands are ignored.
// - Sensitive mode is default; normal mode disables glitch resets.
// - Low battery command with bit 6 set selects normal reset mode.
// - Any reset restores defaults, so sensitive mode returns.
// - Command word FF00h performs a reset equal to power-on reset.
// - Events are processed one at a time and buttons are debounced.
// - The oscillator is switched on for an event when off, then off.
// - Two wake events keep the oscillator on until a status read.
module rowc_reset_osc_ctrl
    import rowc_pkg::*;
#(
    parameter int HOLD_CYC = RESET_HOLD_CYC,
    parameter int DEB_CYC = DEBOUNCE_CYC,
    parameter int NB = NUM_BUTTONS
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic glitch_i,
    input wire logic cmd_valid_i,
    input wire logic [CMD_W-1:0] cmd_word_i,
    input wire logic timer_wake_i,
    input wire logic lowbat_wake_i,
    input wire logic status_read_i,
    input wire logic [NB-1:0] push_button_input_i,
    output logic in_reset_o,
    output logic sensitive_mode_o,
    output logic osc_on_o,
    output logic event_busy_o,
    output logic [NB-1:0] button_state_o,
    output logic cmd_taken_o
);
    localparam int NE = 6;
    localparam int EV_TIMER = 0;
    localparam int EV_LOWBAT = 1;
    localparam int EV_PRESS = 2;
    localparam int EV_RELEASE = 3;
    localparam int EV_STATUS = 4;
    localparam int EV_POR = 5;
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam int DW = $clog2(DEB_CYC + 1);

    rowc_state_t state;
    rowc_state_t next_state;
    logic [HW-1:0] hold_cnt;
    logic reset_req;
    logic [NE-1:0] ev_set;
    logic [NE-1:0] ev_clr;
    logic [NE-1:0] pend;
    logic [NB-1:0] btn_stable;
    logic [NB-1:0] btn_press;
    logic [NB-1:0] btn_release;
    logic wake_unacked;
    logic wake_double;
    logic por_seen;

    initial begin
        if (HOLD_CYC < 1 || DEB_CYC < 1 || NB < 1) begin
            $error("rowc_reset_osc_ctrl: bad parameter value");
        end
    end

    // Wake events are timer, low battery, press and power-on
    function automatic logic is_wake(input logic [NE-1:0] v);
        return v[EV_TIMER] | v[EV_LOWBAT] | v[EV_PRESS] | v[EV_POR];
    endfunction

    assign reset_req = por_i | (glitch_i & sensitive_mode_o)
        | (cmd_valid_i && state != ROWC_RESET && cmd_word_i == CMD_SW_RESET);

    // Reset hold counter, restarts on each reset request
    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            hold_cnt <= HW'(HOLD_CYC);
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - HW'(1);
        end
    end

    // Main sequencer: reset, idle, event service, double-wake hold
    always_comb begin
        next_state = state;
        unique case (state)
            ROWC_RESET: begin
                if (hold_cnt == HW'(1)) begin
                    next_state = ROWC_IDLE;
                end
            end
            ROWC_IDLE: begin
                if (pend != '0) begin
                    next_state = ROWC_BUSY;
                end
            end
            ROWC_BUSY: begin
                if (wake_double) begin
                    next_state = ROWC_HOLD;
                end else if (pend == '0) begin
                    next_state = ROWC_IDLE;
                end
            end
            ROWC_HOLD: begin
                if (!wake_double && pend == '0) begin
                    next_state = ROWC_IDLE;
                end else if (!wake_double) begin
                    next_state = ROWC_BUSY;
                end
            end
        endcase
    end

    // any reset returns to the reset state
    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            state <= ROWC_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            in_reset_o <= 1'b1;
        end else begin
            in_reset_o <= (next_state == ROWC_RESET);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            cmd_taken_o <= 1'b0;
        end else begin
            cmd_taken_o <= cmd_valid_i && state != ROWC_RESET;
        end
    end

    // sensitive by default after any reset
    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            sensitive_mode_o <= 1'b1;
        end else if (cmd_valid_i && state != ROWC_RESET
                && cmd_word_i[CMD_W-1 -: 8] == CMD_LOWBAT_CODE
                && cmd_word_i[LOWBAT_MODE_BIT]) begin
            sensitive_mode_o <= 1'b0;
        end
    end

    // Power-on counts as a wake event once the reset window ends
    always_ff @(posedge clock_i) begin
        if (rst_i || por_i) begin
            por_seen <= 1'b0;
        end else if (state == ROWC_RESET && next_state == ROWC_IDLE) begin
            por_seen <= 1'b1;
        end else begin
            por_seen <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_btn
            logic [DW-1:0] deb_cnt;
            always_ff @(posedge clock_i) begin
                if (rst_i || reset_req) begin
                    deb_cnt <= '0;
                    btn_stable[g] <= 1'b0;
                end else if (push_button_input_i[g] == btn_stable[g]) begin
                    deb_cnt <= '0;
                end else if (deb_cnt == DW'(DEB_CYC - 1)) begin
                    deb_cnt <= '0;
                    btn_stable[g] <= push_button_input_i[g];
                end else begin
                    deb_cnt <= deb_cnt + DW'(1);
                end
            end
            assign btn_press[g] = !btn_stable[g] && push_button_input_i[g]
                && deb_cnt == DW'(DEB_CYC - 1);
            assign btn_release[g] = btn_stable[g] && !push_button_input_i[g]
                && deb_cnt == DW'(DEB_CYC - 1);
        end
    endgenerate

    // Event sources outside reset
    always_comb begin
        ev_set = '0;
        if (state != ROWC_RESET) begin
            ev_set[EV_TIMER] = timer_wake_i;
            ev_set[EV_LOWBAT] = lowbat_wake_i;
            ev_set[EV_PRESS] = |btn_press;
            ev_set[EV_RELEASE] = |btn_release;
            ev_set[EV_STATUS] = status_read_i;
        end
        ev_set[EV_POR] = por_seen;
    end

    // serve lowest pending event first, one per cycle
    always_comb begin
        ev_clr = '0;
        if (state == ROWC_BUSY) begin
            ev_clr = pend & (~pend + NE'(1));
        end
    end

    rowc_event_mem #(
        .N(NE)
    ) u_events (
        .clock_i(clock_i),
        .rst_i(rst_i || reset_req),
        .set_i(ev_set),
        .clr_i(ev_clr),
        .pend_o(pend)
    );

    // track unacknowledged wake events; set wins over status read
    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            wake_unacked <= 1'b0;
            wake_double <= 1'b0;
        end else if (is_wake(ev_set)) begin
            wake_unacked <= 1'b1;
            if (wake_unacked && !status_read_i) begin
                wake_double <= 1'b1;
            end
        end else if (status_read_i) begin
            wake_unacked <= 1'b0;
            wake_double <= 1'b0;
        end
    end

    // oscillator runs while anything is pending or being served
    always_ff @(posedge clock_i) begin
        if (rst_i || reset_req) begin
            osc_on_o <= 1'b0;
            event_busy_o <= 1'b0;
        end else begin
            osc_on_o <= next_state == ROWC_BUSY || next_state == ROWC_HOLD
                || ev_set != '0;
            event_busy_o <= next_state == ROWC_BUSY;
        end
    end

    // Debounced button levels
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            button_state_o <= '0;
        end else begin
            button_state_o <= btn_stable;
        end
    end
endmodule // rowc_reset_osc_ctrl

// >>> tb/rowc_chk.sv
// Port checker for the reset and oscillator wake control block
`timescale 1ns/1ps
module rowc_chk
    import rowc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic glitch_i,
    input wire logic cmd_valid_i,
    input wire logic [CMD_W-1:0] cmd_word_i,
    input wire logic timer_wake_i,
    input wire logic in_reset_o,
    input wire logic sensitive_mode_o,
    input wire logic osc_on_o,
    input wire logic cmd_taken_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Quiet cycle, so no second reset source competes
    logic calm;
    assign calm = !por_i && !glitch_i && !in_reset_o;
    // Reset word clears the take flag, sw_reset_a covers that one
    cmd_taken_a:
    assert property (cmd_valid_i && calm && cmd_word_i != CMD_SW_RESET
        |=> cmd_taken_o) else $error("command not taken");
    cmd_refused_a:
    assert property (cmd_valid_i && in_reset_o |=> !cmd_taken_o)
        else $error("command taken in reset");
    sw_reset_a:
    assert property (cmd_valid_i && calm && cmd_word_i == CMD_SW_RESET
        |=> in_reset_o) else $error("no software reset");
    normal_mode_a:
    assert property (cmd_valid_i && calm && cmd_word_i[LOWBAT_MODE_BIT]
        && cmd_word_i[15:8] == CMD_LOWBAT_CODE |=> !sensitive_mode_o)
        else $error("normal mode not set");
    glitch_reset_a:
    assert property (glitch_i && sensitive_mode_o |=> in_reset_o)
        else $error("glitch gave no reset");
    glitch_ignore_a:
    assert property (glitch_i && !sensitive_mode_o && !in_reset_o
        && !por_i && !cmd_valid_i |=> !in_reset_o)
        else $error("glitch reset in normal mode");
    default_mode_a:
    assert property (in_reset_o |-> sensitive_mode_o)
        else $error("mode not default in reset");
    wake_osc_a:
    assert property (timer_wake_i && calm && !cmd_valid_i |=> osc_on_o)
        else $error("oscillator not woken");
    por_hold_a:
    assert property (por_i |=> in_reset_o [*2])
        else $error("power-on gave no reset");
    cover property (cmd_valid_i && calm && cmd_word_i == CMD_SW_RESET);
    cover property (glitch_i && !sensitive_mode_o);
    cover property (timer_wake_i && calm);
endmodule // rowc_chk

bind rowc_reset_osc_ctrl rowc_chk rowc_chk_inst (.clock_i(clock_i),
    .rst_i(rst_i), .por_i(por_i), .glitch_i(glitch_i),
    .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i),
    .timer_wake_i(timer_wake_i), .in_reset_o(in_reset_o),
    .sensitive_mode_o(sensitive_mode_o), .osc_on_o(osc_on_o),
    .cmd_taken_o(cmd_taken_o));

// >>> tb/rowc_host_model.sv
// Host controller model issuing commands and status reads
`timescale 1ns/1ps
module rowc_host_model (
    input wire logic clock_i,
    input wire logic in_reset_i,
    input wire logic go_i,
    input wire logic rude_i,
    input wire logic rd_i,
    input wire logic [15:0] word_i,
    output logic cmd_valid_o,
    output logic [15:0] cmd_word_o,
    output logic status_read_o
);
    // holds off in reset; rude_i breaks that on purpose
    always_ff @(posedge clock_i) begin
        cmd_valid_o <= go_i && (rude_i || !in_reset_i);
        cmd_word_o <= go_i ? word_i : ~cmd_word_o; // Idle bus toggles
    end
    always_ff @(posedge clock_i) begin
        status_read_o <= rd_i;
    end
endmodule // rowc_host_model

// >>> tb/rowc_reset_osc_ctrl_tb.sv
// Self-checking bench of the reset and oscillator wake control
`timescale 1ns/1ps
module rowc_reset_osc_ctrl_tb;
    import rowc_pkg::*;
    logic clock_i = 0, rst_i = 1, go = 0, rude = 0, rd = 0, cv, sr;
    logic in_rst, sens, osc, busy, taken;
    logic [3:0] ev = 0, btn = 0, bst;
    logic [15:0] wd = 0, cw;
    logic [31:0] lf = 32'h2626;
    int num_errors = 0, n_tests = 0, cyc = 0;
    // Clock and hang guard
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    rowc_host_model rowc_host_model_inst (.clock_i(clock_i),
        .in_reset_i(in_rst), .go_i(go), .rude_i(rude), .rd_i(rd),
        .word_i(wd), .cmd_valid_o(cv), .cmd_word_o(cw),
        .status_read_o(sr));
    rowc_reset_osc_ctrl #(.HOLD_CYC(20), .DEB_CYC(4))
        rowc_reset_osc_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i),
        .por_i(ev[0]), .glitch_i(ev[1]), .cmd_valid_i(cv),
        .cmd_word_i(cw), .timer_wake_i(ev[2]), .lowbat_wake_i(ev[3]),
        .status_read_i(sr), .push_button_input_i(btn),
        .in_reset_o(in_rst), .sensitive_mode_o(sens), .osc_on_o(osc),
        .event_busy_o(busy), .button_state_o(bst), .cmd_taken_o(taken));
    // Galois step, fixed start keeps runs repeatable
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {1'b0, v[31:1]} ^ (v[0] ? 32'hA3000000 : 32'h0);
    endfunction
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Command travels host to design; checks land after the take edge
    task automatic send(input logic [15:0] w);
        @(posedge clock_i) begin go <= 1; wd <= w; end
        @(posedge clock_i) go <= 0;
        @(posedge clock_i) #1;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clock_i) ev <= m;
        @(posedge clock_i) ev <= 0;
        #1;
    endtask
    task automatic wait_out(input bit o);
        for (int i = 0; i < 80 && (o ? osc : in_rst) !== 1'b0; i++)
            @(posedge clock_i) #1;
        chk("release", o ? osc : in_rst, 0);
    endtask
    // Status read that acknowledges wake events, then settle
    task automatic ack();
        @(posedge clock_i) rd <= 1;
        @(posedge clock_i) rd <= 0;
        repeat (3) @(posedge clock_i);
        #1 wait_out(1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 0;
        #1 chk("sens_rst", sens, 1);
        rude = 1;
        send({CMD_LOWBAT_CODE, 8'h40});
        chk("refused", taken, 0);
        chk("sens_kept", sens, 1);
        rude = 0;
        wait_out(0);
        repeat (2) @(posedge clock_i);
        #1 chk("por_wake", osc, 1);
        wait_out(1);
        $display("end reset window");
        lf = nxt(lf);
        @(posedge clock_i) btn <= lf[3:0];
        repeat (12) @(posedge clock_i);
        #1 chk("buttons", bst, lf[3:0]);
        @(posedge clock_i) btn <= 0;
        repeat (12) @(posedge clock_i);
        // Press followed the power-on wake, so a status read is owed
        ack();
        pulse(4'h4);
        chk("osc_wake", osc, 1);
        @(posedge clock_i) #1 chk("busy", busy, 1);
        wait_out(1);
        pulse(4'h4);
        pulse(4'h8);
        repeat (30) @(posedge clock_i);
        #1 chk("osc_held", osc, 1);
        ack();
        $display("end wake tests");
        lf = nxt(lf);
        send({8'hFF, lf[7:0] | 8'h01});
        chk("taken", taken, 1);
        chk("no_reset", in_rst, 0);
        lf = nxt(lf);
        send({CMD_LOWBAT_CODE, lf[7:0] | 8'h40});
        chk("normal", sens, 0);
        pulse(4'h2);
        chk("glitch_off", in_rst, 0);
        send(CMD_SW_RESET);
        chk("sw_reset", in_rst, 1);
        chk("sens_back", sens, 1);
        wait_out(0);
        pulse(4'h2);
        chk("glitch_on", in_rst, 1);
        wait_out(0);
        pulse(4'h1);
        chk("por", in_rst, 1);
        wait_out(0);
        $display("end reset tests");
        print_verdict();
    end
endmodule // rowc_reset_osc_ctrl_tb
